// File: ebr_pkg.sv
package ebr_pkg;

    // Array geometry: full block, half block for packed use, port widths.
    localparam int unsigned EBR_MEM_BITS  = 4608;
    localparam int unsigned EBR_HALF_BITS = 2304;
    localparam int unsigned EBR_MAX_TAPW  = 36;
    localparam int unsigned EBR_AW        = 12;
    localparam int unsigned EBR_DW        = 36;
    localparam int unsigned EBR_RAW       = 4;

    // Register offsets on the plain register port.
    localparam logic [3:0] EBR_REG_CFG   = 4'h0;
    localparam logic [3:0] EBR_REG_SHIFT = 4'h4;
    localparam logic [3:0] EBR_REG_STAT  = 4'h8;

    // Reset values and writable masks.
    localparam logic [31:0] EBR_CFG_RST    = 32'h0000_0000;
    localparam logic [31:0] EBR_SHIFT_RST  = 32'h0001_0001;
    localparam logic [31:0] EBR_CFG_MASK   = 32'h0003_3fff;
    localparam logic [31:0] EBR_SHIFT_MASK = 32'h003f_1fff;

    // Field positions of the configuration register.
    localparam int unsigned EBR_CFG_MODE_LSB = 0;
    localparam int unsigned EBR_CFG_SHA_LSB  = 4;
    localparam int unsigned EBR_CFG_SHB_LSB  = 8;
    localparam int unsigned EBR_CFG_ORA_BIT  = 12;
    localparam int unsigned EBR_CFG_ORB_BIT  = 13;
    localparam int unsigned EBR_CFG_CLK_LSB  = 16;

    // Field positions of the shift register geometry register.
    localparam int unsigned EBR_SH_LEN_LSB  = 0;
    localparam int unsigned EBR_SH_TAPS_LSB = 16;

    // Sticky status bits, cleared by writing one.
    localparam int unsigned EBR_ST_SP_BOTH  = 0;
    localparam int unsigned EBR_ST_COLLIDE  = 1;
    localparam int unsigned EBR_ST_CFG_BAD  = 2;
    localparam int unsigned EBR_ST_SH_BAD   = 3;
    localparam logic [3:0]  EBR_STAT_RST    = 4'h0;

    // Memory modes.
    typedef enum logic [2:0] {
        EBR_SP     = 3'h0,
        EBR_SDP    = 3'h1,
        EBR_TDP    = 3'h2,
        EBR_SHIFT  = 3'h3,
        EBR_ROM    = 3'h4,
        EBR_FIFO   = 3'h5,
        EBR_PACKED = 3'h6
    } ebr_mode_t;

    // Port shapes, depth by width.
    typedef enum logic [3:0] {
        EBR_4KX1   = 4'h0,
        EBR_2KX2   = 4'h1,
        EBR_1KX4   = 4'h2,
        EBR_512X8  = 4'h3,
        EBR_512X9  = 4'h4,
        EBR_256X16 = 4'h5,
        EBR_256X18 = 4'h6,
        EBR_128X32 = 4'h7,
        EBR_128X36 = 4'h8
    } ebr_shape_t;

    // Clocking arrangements.
    typedef enum logic [1:0] {
        EBR_CK_INDEP  = 2'h0,
        EBR_CK_INOUT  = 2'h1,
        EBR_CK_RDWR   = 2'h2,
        EBR_CK_SINGLE = 2'h3
    } ebr_clk_t;

    // One port request as it arrives from user logic.
    typedef struct packed {
        logic              we;
        logic              re;
        logic [EBR_AW-1:0] addr;
        logic [EBR_DW-1:0] wdata;
    } ebr_req_t;

endpackage

// File: ebr_block_ram.sv
`timescale 1ns/1ps

// Behaviour
// - single-port performs a read or a write per cycle, never both.
// - single-port write passes the written word straight to the read output.
// - single-port offers nine shapes from 4Kx1 to 128x36, one selected.
// - packed mode hosts two independent single-port memories in one block.
// - simple dual-port takes one read and one write in the same cycle.
// - simple dual-port mixes widths within 1..32 group or 9/18/36 group only.
// - simple dual-port has one write enable, one read enable, no input clear.
// - simple dual-port holds its read output while read enable is low.
// - simple dual-port read of the address being written returns old data.
// - true dual-port lets both ports read or write independently each cycle.
// - true dual-port widest shape is 256x16 or 256x18; 32/36 wide refused.
// - true dual-port mixes widths within 1..16 group or 9/18 group only.
// - true dual-port write passes the word to that same port's output.
// - shift mode writes and reads each slot so data advances once per cycle.
// - ROM mode reads like single-port, registered address, no writes.
// - FIFO use registers inputs and presents read data without output register.
// - clock arrangement must suit the memory mode as allowed per mode.
// - each port's registers follow that port's own clock enable, no clear; here i_rst_n clears the output registers regardless of enable.
// - inputs always registered; output pipelined or flow-through as chosen.
// - a low clock enable stops every operation of the logic it governs.
// - mixed-port read during write on two clocks gives an undefined value.
module ebr_block_ram (
    // Clock and reset.
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst_n,
    // Register port.
    input  wire logic [3:0]        i_reg_addr,
    input  wire logic [31:0]       i_reg_wdata,
    input  wire logic              i_reg_wr,
    input  wire logic              i_reg_rd,
    output logic      [31:0]       o_reg_rdata,
    // Port A.
    input  wire logic              i_ce_a,
    input  wire ebr_pkg::ebr_req_t i_req_a,
    output logic      [35:0]       o_rdata_a,
    // Port B.
    input  wire logic              i_ce_b,
    input  wire ebr_pkg::ebr_req_t i_req_b,
    output logic      [35:0]       o_rdata_b
);

    // Word width of a shape.
    // nine shapes decoded.
    function automatic logic [5:0] shp_w(input ebr_pkg::ebr_shape_t s);
        case (s)
            ebr_pkg::EBR_4KX1:   shp_w = 6'h01;
            ebr_pkg::EBR_2KX2:   shp_w = 6'h02;
            ebr_pkg::EBR_1KX4:   shp_w = 6'h04;
            ebr_pkg::EBR_512X8:  shp_w = 6'h08;
            ebr_pkg::EBR_512X9:  shp_w = 6'h09;
            ebr_pkg::EBR_256X16: shp_w = 6'h10;
            ebr_pkg::EBR_256X18: shp_w = 6'h12;
            ebr_pkg::EBR_128X32: shp_w = 6'h20;
            ebr_pkg::EBR_128X36: shp_w = 6'h24;
            default:             shp_w = 6'h01;
        endcase
    endfunction

    // Address bits used by a shape, the log2 of its depth.
    function automatic logic [3:0] shp_ab(input ebr_pkg::ebr_shape_t s);
        case (s)
            ebr_pkg::EBR_4KX1:   shp_ab = 4'hc;
            ebr_pkg::EBR_2KX2:   shp_ab = 4'hb;
            ebr_pkg::EBR_1KX4:   shp_ab = 4'ha;
            ebr_pkg::EBR_512X8,
            ebr_pkg::EBR_512X9:  shp_ab = 4'h9;
            ebr_pkg::EBR_256X16,
            ebr_pkg::EBR_256X18: shp_ab = 4'h8;
            default:             shp_ab = 4'h7;
        endcase
    endfunction

    // Shapes that carry the ninth bit per byte.
    function automatic logic shp_par(input ebr_pkg::ebr_shape_t s);
        shp_par = (s == ebr_pkg::EBR_512X9) || (s == ebr_pkg::EBR_256X18) ||
                  (s == ebr_pkg::EBR_128X36);
    endfunction

    // First array bit of a word; packed halves lose their top address bit.
    function automatic logic [12:0] bit_base(input ebr_pkg::ebr_shape_t s,
                                             input logic [11:0] a, input logic half);
        logic [3:0]  ab;
        logic [24:0] p;
        ab = shp_ab(s) - {3'h0, half};
        p  = 25'(a & ~(12'hfff << ab)) * 25'(shp_w(s));
        bit_base = p[12:0];
    endfunction

    // Mask of the live data bits of a shape.
    function automatic logic [35:0] shp_mask(input ebr_pkg::ebr_shape_t s);
        shp_mask = ~(36'hf_ffff_ffff << shp_w(s));
    endfunction

    // Configuration, shift geometry and sticky status.
    logic [31:0]         cfg_ff;
    logic [31:0]         shcfg_ff;
    logic [3:0]          stat_ff;
    logic [31:0]         reg_rdata_ff;
    ebr_pkg::ebr_mode_t  mode;
    ebr_pkg::ebr_shape_t sh_a;
    ebr_pkg::ebr_shape_t sh_b;
    ebr_pkg::ebr_clk_t   ck;
    logic [12:0]         sh_len;
    logic [5:0]          sh_taps;
    logic                cfg_bad;
    logic                sh_bad;

    assign mode    = ebr_pkg::ebr_mode_t'(cfg_ff[ebr_pkg::EBR_CFG_MODE_LSB +: 3]);
    assign sh_a    = ebr_pkg::ebr_shape_t'(cfg_ff[ebr_pkg::EBR_CFG_SHA_LSB +: 4]);
    assign sh_b    = ebr_pkg::ebr_shape_t'(cfg_ff[ebr_pkg::EBR_CFG_SHB_LSB +: 4]);
    assign ck      = ebr_pkg::ebr_clk_t'(cfg_ff[ebr_pkg::EBR_CFG_CLK_LSB +: 2]);
    assign sh_len  = shcfg_ff[ebr_pkg::EBR_SH_LEN_LSB +: 13];
    assign sh_taps = shcfg_ff[ebr_pkg::EBR_SH_TAPS_LSB +: 6];

    // Legality of the chosen shapes and clocking; an illegal set freezes both ports.
    always_comb begin
        cfg_bad = (sh_a > ebr_pkg::EBR_128X36) || (sh_b > ebr_pkg::EBR_128X36) ||
                  (mode > ebr_pkg::EBR_PACKED);
        if ((mode == ebr_pkg::EBR_SDP) || (mode == ebr_pkg::EBR_FIFO) ||
            (mode == ebr_pkg::EBR_TDP)) begin
            cfg_bad = cfg_bad || (shp_par(sh_a) != shp_par(sh_b));
        end
        // no 32 or 36 wide port in true dual-port.
        if (mode == ebr_pkg::EBR_TDP) begin
            cfg_bad = cfg_bad || (shp_w(sh_a) > 6'h12) || (shp_w(sh_b) > 6'h12);
        end
        // packed halves are at most 18 bits wide and single-clocked.
        if (mode == ebr_pkg::EBR_PACKED) begin
            cfg_bad = cfg_bad || (shp_w(sh_a) > 6'h12) || (shp_w(sh_b) > 6'h12) ||
                      (ck != ebr_pkg::EBR_CK_SINGLE);
        end
        if ((ck == ebr_pkg::EBR_CK_INDEP) && (mode != ebr_pkg::EBR_TDP)) begin
            cfg_bad = 1'b1;
        end
        if ((ck == ebr_pkg::EBR_CK_RDWR) && (mode != ebr_pkg::EBR_SDP) &&
            (mode != ebr_pkg::EBR_FIFO)) begin
            cfg_bad = 1'b1;
        end
    end

    // shift geometry is checked here so a bad set never overruns the array.
    logic [24:0] sh_bits;
    logic [12:0] sh_ent;
    assign sh_ent  = 13'(25'(sh_len) * 25'(sh_taps));
    assign sh_bits = 25'(sh_len) * 25'(sh_taps) * 25'(shp_w(sh_a));
    assign sh_bad  = (mode == ebr_pkg::EBR_SHIFT) &&
                     ((sh_len == 13'h0) || (sh_taps == 6'h0) ||
                      (sh_bits > 25'(ebr_pkg::EBR_MEM_BITS)) ||
                      (12'(sh_taps) * 12'(shp_w(sh_a)) > 12'(ebr_pkg::EBR_MAX_TAPW)));

    // Effective operations per port after mode, enable and legality.
    logic        ok;
    logic        we_a;
    logic        re_a;
    logic        we_b;
    logic        re_b;
    logic        sp_both;
    logic        collide;
    logic [12:0] base_a;
    logic [12:0] base_b;
    logic [35:0] wword_a;
    logic [35:0] wword_b;
    logic        is_sp;
    logic        is_sdp;

    assign ok      = !cfg_bad && !sh_bad;
    assign is_sp   = (mode == ebr_pkg::EBR_SP) || (mode == ebr_pkg::EBR_PACKED);
    assign is_sdp  = (mode == ebr_pkg::EBR_SDP) || (mode == ebr_pkg::EBR_FIFO);
    // nothing happens on a port whose enable is low.
    // the ROM never takes a write.
    // in simple dual-port A only writes and B only reads, both in one cycle.
    // one write enable and one read enable in simple dual-port.
    assign we_a    = i_ce_a && ok && i_req_a.we &&
                     (is_sp || is_sdp || (mode == ebr_pkg::EBR_TDP));
    // a single-port write takes the cycle; a read asked beside it is dropped.
    assign re_a    = i_ce_a && ok && i_req_a.re && !(is_sp && i_req_a.we) &&
                     (is_sp || (mode == ebr_pkg::EBR_TDP) || (mode == ebr_pkg::EBR_ROM));
    // port B reads or writes on its own in true dual-port.
    assign we_b    = i_ce_b && ok && i_req_b.we &&
                     ((mode == ebr_pkg::EBR_TDP) || (mode == ebr_pkg::EBR_PACKED));
    assign re_b    = i_ce_b && ok && i_req_b.re &&
                     !((mode == ebr_pkg::EBR_PACKED) && i_req_b.we) &&
                     (is_sdp || (mode == ebr_pkg::EBR_TDP) ||
                      (mode == ebr_pkg::EBR_PACKED));
    assign sp_both = ok && is_sp && ((i_ce_a && i_req_a.we && i_req_a.re) ||
                     ((mode == ebr_pkg::EBR_PACKED) && i_ce_b && i_req_b.we && i_req_b.re));
    // only log2(depth) address bits take part in the word position.
    // port B of a packed block lives in the upper half of the array.
    assign base_a  = bit_base(sh_a, i_req_a.addr, mode == ebr_pkg::EBR_PACKED);
    assign base_b  = bit_base(sh_b, i_req_b.addr, mode == ebr_pkg::EBR_PACKED) +
                     ((mode == ebr_pkg::EBR_PACKED) ? 13'(ebr_pkg::EBR_HALF_BITS) : 13'h0);
    assign wword_a = i_req_a.wdata & shp_mask(sh_a);
    assign wword_b = i_req_b.wdata & shp_mask(sh_b);
    // a double write to one word is flagged; port B's bits are the ones stored.
    assign collide = we_a && we_b && (mode == ebr_pkg::EBR_TDP) && (base_a == base_b);

    // Storage, one bit per entry so mixed widths share one address space.
    logic        mem_ff [ebr_pkg::EBR_MEM_BITS];
    logic [12:0] ptr_ff;
    logic [35:0] rd_a;
    logic [35:0] rd_b;
    logic [35:0] sh_q;

    // Read words as stored before this edge's writes.
    always_comb begin
        int idx;
        idx  = 0;
        rd_a = 36'h0;
        rd_b = 36'h0;
        for (int i = 0; i < ebr_pkg::EBR_DW; i++) begin
            idx = int'(base_a) + i;
            if ((i < int'(shp_w(sh_a))) && (idx < ebr_pkg::EBR_MEM_BITS)) begin
                rd_a[i] = mem_ff[idx];
            end
            idx = int'(base_b) + i;
            if ((i < int'(shp_w(sh_b))) && (idx < ebr_pkg::EBR_MEM_BITS)) begin
                rd_b[i] = mem_ff[idx];
            end
        end
    end

    // Shift taps: tap k shows the word written (k+1)*length cycles ago.
    always_comb begin
        int ent;
        int pos;
        ent  = 0;
        pos  = 0;
        sh_q = 36'h0;
        for (int k = 0; k < ebr_pkg::EBR_DW; k++) begin
            ent = int'(ptr_ff) + int'(sh_ent) - (k + 1) * int'(sh_len);
            if (ent >= int'(sh_ent)) begin
                ent = ent - int'(sh_ent);
            end
            for (int i = 0; i < ebr_pkg::EBR_DW; i++) begin
                pos = k * int'(shp_w(sh_a)) + i;
                if ((k < int'(sh_taps)) && (i < int'(shp_w(sh_a))) && (pos < 36) &&
                    (ent >= 0) && (ent * int'(shp_w(sh_a)) + i < ebr_pkg::EBR_MEM_BITS)) begin
                    sh_q[pos] = mem_ff[ent * int'(shp_w(sh_a)) + i];
                end
            end
        end
    end

    // Array writes; contents have no reset, as in the real block.
    // nonblocking update lets a same-edge read see the old word.
    // one clock only, so the two-clock undefined case cannot arise.
    always_ff @(posedge i_clk_sys) begin
        for (int i = 0; i < ebr_pkg::EBR_DW; i++) begin
            // the slot under the pointer is read then overwritten each enabled cycle.
            if ((mode == ebr_pkg::EBR_SHIFT) && i_ce_a && ok &&
                (i < int'(shp_w(sh_a)))) begin
                mem_ff[int'(ptr_ff) * int'(shp_w(sh_a)) + i] <= i_req_a.wdata[i];
            end
            if (we_a && (i < int'(shp_w(sh_a)))) begin
                mem_ff[int'(base_a) + i] <= i_req_a.wdata[i];
            end
            if (we_b && (i < int'(shp_w(sh_b)))) begin
                mem_ff[int'(base_b) + i] <= i_req_b.wdata[i];
            end
        end
    end

    // Shift pointer walks the circular slot range once per enabled cycle.
    // Other modes park it at zero only on enabled edges, so a low enable freezes it.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ptr_ff <= 13'h0;
        end else if (i_ce_a) begin
            if ((mode != ebr_pkg::EBR_SHIFT) || sh_bad || (ptr_ff + 13'h1 >= sh_ent)) begin
                ptr_ff <= 13'h0;
            end else begin
                ptr_ff <= ptr_ff + 13'h1;
            end
        end
    end

    // Port outputs: first stage is the flow-through word, second the output register.
    logic [35:0] q_a_ff;
    logic [35:0] q_b_ff;
    logic [35:0] q2_a_ff;
    logic [35:0] q2_b_ff;

    // port A state follows only port A's enable.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            q_a_ff  <= 36'h0;
            q2_a_ff <= 36'h0;
        end else if (i_ce_a) begin
            q2_a_ff <= q_a_ff;
            if ((mode == ebr_pkg::EBR_SHIFT) && ok) begin
                q_a_ff <= sh_q;
            // true dual-port write-through on port A.
            end else if (we_a && !is_sdp) begin
                q_a_ff <= wword_a;
            end else if (re_a) begin
                q_a_ff <= rd_a;
            end
        end
    end

    // port B state follows only port B's enable.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            q_b_ff  <= 36'h0;
            q2_b_ff <= 36'h0;
        end else if (i_ce_b) begin
            q2_b_ff <= q_b_ff;
            // true dual-port write-through on port B.
            if (we_b) begin
                q_b_ff <= wword_b;
            // without a read enable the last word stays.
            end else if (re_b) begin
                q_b_ff <= rd_b;
            end
        end
    end

    // FIFO use always presents the flow-through word.
    assign o_rdata_a = (cfg_ff[ebr_pkg::EBR_CFG_ORA_BIT] && (mode != ebr_pkg::EBR_FIFO)) ?
                       q2_a_ff : q_a_ff;
    assign o_rdata_b = (cfg_ff[ebr_pkg::EBR_CFG_ORB_BIT] && (mode != ebr_pkg::EBR_FIFO)) ?
                       q2_b_ff : q_b_ff;

    // Register writes; the status clear loses to a new event in the same cycle.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cfg_ff   <= ebr_pkg::EBR_CFG_RST;
            shcfg_ff <= ebr_pkg::EBR_SHIFT_RST;
            stat_ff  <= ebr_pkg::EBR_STAT_RST;
        end else begin
            if (i_reg_wr && (i_reg_addr == ebr_pkg::EBR_REG_CFG)) begin
                cfg_ff <= i_reg_wdata & ebr_pkg::EBR_CFG_MASK;
            end
            if (i_reg_wr && (i_reg_addr == ebr_pkg::EBR_REG_SHIFT)) begin
                shcfg_ff <= i_reg_wdata & ebr_pkg::EBR_SHIFT_MASK;
            end
            stat_ff <= (stat_ff & ~((i_reg_wr && (i_reg_addr == ebr_pkg::EBR_REG_STAT)) ?
                                    i_reg_wdata[3:0] : 4'h0)) |
                       {sh_bad, cfg_bad, collide, sp_both};
        end
    end

    // Read data stands only in the cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || !i_reg_rd) begin
            reg_rdata_ff <= 32'h0;
        end else begin
            case (i_reg_addr)
                ebr_pkg::EBR_REG_CFG:   reg_rdata_ff <= cfg_ff;
                ebr_pkg::EBR_REG_SHIFT: reg_rdata_ff <= shcfg_ff;
                ebr_pkg::EBR_REG_STAT:  reg_rdata_ff <= {28'h0, stat_ff};
                default:                reg_rdata_ff <= 32'h0;
            endcase
        end
    end
    assign o_reg_rdata = reg_rdata_ff;

    // Checks on the behaviour above.
    a_sp_write_thru: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (is_sp && we_a) |=> (q_a_ff == $past(wword_a)))
        else $error("single-port write not passed to output");
    a_sp_one_op: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (is_sp && we_a) |-> !re_a)
        else $error("single-port read and write in one cycle");
    a_sdp_hold_out: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (is_sdp && i_ce_b && !i_req_b.re) |=> $stable(q_b_ff))
        else $error("read output moved without read enable");
    a_sdp_old_data: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (is_sdp && we_a && re_b && (base_a == base_b) && (sh_a == sh_b) &&
         (rd_b != wword_a)) |=> (q_b_ff != $past(wword_a)))
        else $error("same-address read returned new data");
    a_ce_freeze: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !i_ce_a |=> ($stable(q_a_ff) && $stable(q2_a_ff) && $stable(ptr_ff)))
        else $error("port A changed with enable low");
    a_tdp_no_wide: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        ((mode == ebr_pkg::EBR_TDP) && (shp_w(sh_a) > 6'h12)) |-> (!we_a && !re_a))
        else $error("wide shape accepted in true dual-port");
    a_rom_no_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (mode == ebr_pkg::EBR_ROM) |-> !we_a && !we_b)
        else $error("ROM took a write");
    a_fifo_flow: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (mode == ebr_pkg::EBR_FIFO) |-> (o_rdata_b == q_b_ff) && (o_rdata_a == q_a_ff))
        else $error("FIFO output passed through output register");
    a_out_pipe: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_ce_a && cfg_ff[ebr_pkg::EBR_CFG_ORA_BIT] && (mode != ebr_pkg::EBR_FIFO) &&
         !(i_reg_wr && (i_reg_addr == ebr_pkg::EBR_REG_CFG))) |=>
        (o_rdata_a == $past(q_a_ff)))
        else $error("output register stage missing");
    a_mix_group: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (is_sdp && (shp_par(sh_a) != shp_par(sh_b))) |=> stat_ff[ebr_pkg::EBR_ST_CFG_BAD])
        else $error("mixed width groups not flagged");

endmodule // ebr_block_ram

// File: ebr_user_model.sv
`timescale 1ns/1ps
// Fabric-side user logic: puts one staged request per cycle on a memory port.
module ebr_user_model (
    // Clock.
    input  wire logic              i_clk_sys,
    // Staged command.
    input  wire logic              i_ce,
    input  wire ebr_pkg::ebr_req_t i_cmd,
    input  wire logic              i_allow_both,
    // Memory port request.
    output logic                   o_ce,
    output ebr_pkg::ebr_req_t      o_req
);
    // read or write
    // Idle we, addr and wdata show the inverse word and re is cleared, so a stale request never looks valid.
    always_ff @(posedge i_clk_sys) begin
        o_ce        <= i_ce;
        o_req.we    <= i_ce ? i_cmd.we : ~i_cmd.we;
        o_req.re    <= i_ce & i_cmd.re & (i_allow_both | ~i_cmd.we);
        o_req.addr  <= i_ce ? i_cmd.addr : ~i_cmd.addr;
        o_req.wdata <= i_ce ? i_cmd.wdata : ~i_cmd.wdata;
    end
endmodule // ebr_user_model

// File: ebr_block_ram_bench.sv
`timescale 1ns/1ps
module ebr_block_ram_bench;
    typedef struct packed {
        logic        we;
        logic        re;
        logic [11:0] addr;
        logic [35:0] wd;
        logic [35:0] exp;
    } ebr_row_t;
    // Single-port 512x8 cases: write-through, masking above width, read back.
    localparam ebr_row_t ROWS [4] = '{
        '{1'b1, 1'b0, 12'h005, 36'h0a5, 36'h0a5},
        '{1'b1, 1'b0, 12'h006, 36'h1ff, 36'h0ff},
        '{1'b0, 1'b1, 12'h005, 36'h000, 36'h0a5},
        '{1'b0, 1'b1, 12'h006, 36'h000, 36'h0ff}};
    logic              i_clk_sys = 1'b0;
    logic              i_rst_n   = 1'b0;
    logic [3:0]        reg_addr  = 4'h0;
    logic [31:0]       reg_wdata = 32'h0;
    logic              reg_wr    = 1'b0;
    logic              reg_rd    = 1'b0;
    logic              ce_a      = 1'b0;
    logic              ce_b      = 1'b0;
    logic              both      = 1'b0;
    ebr_pkg::ebr_req_t cmd_a     = '0;
    ebr_pkg::ebr_req_t cmd_b     = '0;
    logic              ce_a_q, ce_b_q;
    ebr_pkg::ebr_req_t req_a, req_b;
    logic [31:0]       rdata;
    logic [35:0]       rd_a, rd_b;
    int                n_errors = 0;
    int                samples_checked = 0;

    // Clock at 200 MHz.
    always #2.5 i_clk_sys = ~i_clk_sys;

    ebr_user_model u_pa (.i_clk_sys(i_clk_sys), .i_ce(ce_a), .i_cmd(cmd_a),
        .i_allow_both(both), .o_ce(ce_a_q), .o_req(req_a));
    ebr_user_model u_pb (.i_clk_sys(i_clk_sys), .i_ce(ce_b), .i_cmd(cmd_b),
        .i_allow_both(both), .o_ce(ce_b_q), .o_req(req_b));
    ebr_block_ram u_dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_reg_addr(reg_addr),
        .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(rdata),
        .i_ce_a(ce_a_q), .i_req_a(req_a), .o_rdata_a(rd_a),
        .i_ce_b(ce_b_q), .i_req_b(req_b), .o_rdata_b(rd_b));

    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Bus tasks start and end at a rising edge; an idle edge keeps strobes single.
    task automatic reg_put(input logic [3:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge i_clk_sys);
        reg_wr <= 1'b0;
        @(posedge i_clk_sys);
    endtask

    // Read data is looked at the edge after capture, while it still stands.
    task automatic reg_chk(input logic [3:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge i_clk_sys);
        reg_rd <= 1'b0;
        @(posedge i_clk_sys);
        check("register", {4'h0, rdata}, {4'h0, exp});
    endtask

    // One port operation: the partner issues it, the block takes it an edge later.
    task automatic port(input logic ea, input logic eb, input ebr_pkg::ebr_req_t ra,
                        input ebr_pkg::ebr_req_t rb);
        ce_a  <= ea;
        ce_b  <= eb;
        cmd_a <= ra;
        cmd_b <= rb;
        @(posedge i_clk_sys);
        ce_a <= 1'b0;
        ce_b <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
    endtask

    // Watchdog against a hang.
    initial begin
        #50000;
        n_errors++;
        end_of_test();
    end

    // Main sequence.
    initial begin
        repeat (5) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        // The first edge out of reset sets the sticky bit read next.
        @(posedge i_clk_sys);
        reg_chk(4'h8, 32'h4);
        reg_chk(4'h4, 32'h0001_0001);
        reg_chk(4'hc, 32'h0);
        reg_put(4'h0, 32'h0003_0330);
        reg_put(4'h8, 32'hf);
        reg_chk(4'h8, 32'h0);
        foreach (ROWS[i]) begin
            port(1'b1, 1'b0, {ROWS[i].we, ROWS[i].re, ROWS[i].addr, ROWS[i].wd}, '0);
            check("sp_row", rd_a, ROWS[i].exp);
        end
        port(1'b0, 1'b0, {1'b1, 1'b0, 12'h005, 36'h011}, '0);
        check("ce_low_hold", rd_a, 36'h0ff);
        port(1'b1, 1'b0, {1'b0, 1'b1, 12'h005, 36'h0}, '0);
        check("ce_low_nowrite", rd_a, 36'h0a5);
        both <= 1'b1;
        port(1'b1, 1'b0, {1'b1, 1'b1, 12'h005, 36'h077}, '0);
        check("sp_both", rd_a, 36'h077);
        reg_chk(4'h8, 32'h1);
        reg_put(4'h0, 32'h0003_0331);
        reg_put(4'h8, 32'hf);
        port(1'b1, 1'b1, {1'b1, 1'b0, 12'h005, 36'h011}, {1'b0, 1'b1, 12'h005, 36'h0});
        check("sdp_old", rd_b, 36'h077);
        port(1'b1, 1'b1, {1'b1, 1'b0, 12'h005, 36'h022}, {1'b0, 1'b0, 12'h005, 36'h0});
        check("sdp_hold", rd_b, 36'h077);
        port(1'b0, 1'b1, '0, {1'b0, 1'b1, 12'h005, 36'h0});
        check("sdp_read", rd_b, 36'h022);
        // True dual-port: distinct words on both ports, then read crosswise.
        reg_put(4'h0, 32'h0003_0332);
        port(1'b1, 1'b1, {1'b1, 1'b0, 12'h007, 36'h033},
             {1'b1, 1'b0, 12'h008, 36'h044});
        check("tdp_thru_a", rd_a, 36'h033);
        check("tdp_thru_b", rd_b, 36'h044);
        port(1'b1, 1'b1, {1'b0, 1'b1, 12'h008, 36'h0},
             {1'b0, 1'b1, 12'h007, 36'h0});
        check("tdp_read_a", rd_a, 36'h044);
        check("tdp_read_b", rd_b, 36'h033);
        reg_put(4'h0, 32'h0003_0772);
        reg_chk(4'h8, 32'h4);
        // Output register on port A: a word shows one enabled edge later.
        reg_put(4'h0, 32'h0003_1330);
        port(1'b1, 1'b0, {1'b1, 1'b0, 12'h009, 36'h05a}, '0);
        check("pipe_first", rd_a, 36'h044);
        port(1'b1, 1'b0, {1'b0, 1'b1, 12'h009, 36'h0}, '0);
        check("pipe_second", rd_a, 36'h05a);
        // FIFO use ignores the output register selects; write and read never share a cycle.
        reg_put(4'h0, 32'h0003_3335);
        port(1'b1, 1'b0, {1'b1, 1'b0, 12'h002, 36'h066}, '0);
        port(1'b0, 1'b1, '0, {1'b0, 1'b1, 12'h002, 36'h0});
        check("fifo_flow", rd_b, 36'h066);
        reg_put(4'h0, 32'h0003_0334);
        port(1'b1, 1'b0, {1'b1, 1'b1, 12'h002, 36'h099}, '0);
        check("rom_read", rd_a, 36'h066);
        // Mid-run reset clears both outputs and the configuration.
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        check("rst_out_a", rd_a, 36'h0);
        check("rst_out_b", rd_b, 36'h0);
        reg_chk(4'h0, 32'h0);
        end_of_test();
    end
endmodule // ebr_block_ram_bench
